/* File: src/scc_top.sv */
// system control coprocessor: control registers, translation, timer, watch
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - cycle counter advances once every two clock cycles.
// - counter reaching the compare value raises the timer interrupt.
// - an address fault captures its virtual address in faulting_vaddr, the data one if both fault.
// - region_cache_policy holds one attribute per 512MB region, eight regions.
// - reset and every recognised exception put the device in kernel mode.
// - kernel mode reaches all space and registers; ST_FPU_EN alone gates float coprocessor use, in either mode.
// - user mode is limited to user space; control access may be inhibited.
// - upper half of space is kernel only; user access there faults.
// - user fetches check the instruction limit, loads and stores the data limit.
// - in-bounds user address plus matching base gives the physical address.
// - out-of-bounds user address signals an address fault instead.
// - kernel segment addresses skip base and limit, fixed mapping.
// - enabled watch matches on fetch or data address cause an exception.
// - with the dedicated vector enabled, interrupts go there, else general vector.
// - exception pc goes to exception_return_pc, cache errors to error_return_pc.
module scc_top #(
  parameter logic [31:0] PROC_ID = 32'h0000_0a01 // arbitrary identity value
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // axi4-lite write address, data and response
  input wire logic awvalid_in,
  input wire logic [7:0] awaddr_in,
  output logic awready_out,
  input wire logic wvalid_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic wready_out,
  output logic bvalid_out,
  output logic [1:0] bresp_out,
  input wire logic bready_in,
  // axi4-lite read
  input wire logic arvalid_in,
  input wire logic [7:0] araddr_in,
  output logic arready_out,
  output logic rvalid_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  input wire logic rready_in,
  // pipeline accesses
  input wire logic fetch_valid_in,
  input wire logic [31:0] fetch_vaddr_in,
  input wire logic data_valid_in,
  input wire logic [31:0] data_vaddr_in,
  // pipeline exception report
  input wire logic exc_take_in,
  input wire logic [4:0] exc_code_in,
  input wire logic [31:0] exc_pc_in,
  input wire logic exc_cache_err_in,
  input wire logic [31:0] cache_err_info_in,
  // translation results
  output logic fetch_valid_out,
  output logic [31:0] fetch_paddr_out,
  output logic fetch_fault_out,
  output logic data_valid_out,
  output logic [31:0] data_paddr_out,
  output logic data_fault_out,
  output logic watch_exc_out,
  // mode and exception outputs
  output logic user_mode_out,
  output logic ctl_usable_out,
  output logic fpu_usable_out,
  output logic [31:0] exc_vector_out,
  output logic irq_out
);
  import scc_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [5:0] aw_idx;
    logic aw_rdy;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_rdy;
    logic bvalid;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [31:0] instr_space_base;
    logic [31:0] instr_space_limit;
    logic [31:0] data_space_base;
    logic [31:0] data_space_limit;
    logic [31:0] badva;
    logic [31:0] count;
    logic [31:0] compare;
    logic [31:0] status;
    logic [31:0] cause;
    logic [31:0] exception_return_pc;
    logic [31:0] sysattr;
    logic [31:0] region_cache_policy;
    logic [31:0] instr_breakpoint_addr;
    logic [31:0] data_breakpoint_addr;
    logic [31:0] ecc;
    logic [31:0] cerr;
    logic [31:0] cache_tag_low;
    logic [31:0] errpc;
    logic [NUM_EV-1:0] irq_st;
    logic [NUM_EV-1:0] irq_mask;
    logic half;
    logic f_valid;
    logic [31:0] f_paddr;
    logic f_fault;
    logic d_valid;
    logic [31:0] d_paddr;
    logic d_fault;
    logic watch_exc;
    logic ctl_ok;
    logic [31:0] exc_vec;
    logic irq;
  } scc_state_t;

  scc_state_t s;
  scc_state_t next_s;
  logic [31:0] xi_paddr;
  logic [31:0] xd_paddr;
  logic xi_fault;
  logic xd_fault;
  logic xi_watch;
  logic xd_watch;
  logic wr_commit;
  logic count_written;
  logic timer_hit;
  logic [31:0] rd_mux;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // instruction stream uses the instruction base and limit
  scc_xlate u_xlate_i (
    .vaddr_in(fetch_vaddr_in),
    .user_in(s.status[ST_USER]),
    .base_in(s.instr_space_base),
    .limit_in(s.instr_space_limit),
    .watch_addr_in(s.instr_breakpoint_addr),
    .watch_en_in(s.status[ST_WATCH_EN]),
    .paddr_out(xi_paddr),
    .fault_out(xi_fault),
    .watch_hit_out(xi_watch)
  );

  // data stream uses the data base and limit
  scc_xlate u_xlate_d (
    .vaddr_in(data_vaddr_in),
    .user_in(s.status[ST_USER]),
    .base_in(s.data_space_base),
    .limit_in(s.data_space_limit),
    .watch_addr_in(s.data_breakpoint_addr),
    .watch_en_in(s.status[ST_WATCH_EN]),
    .paddr_out(xd_paddr),
    .fault_out(xd_fault),
    .watch_hit_out(xd_watch)
  );

  // register read decode; unused numbers read zero
  always_comb begin
    case (araddr_in[7:2])
      IDX_ISPACE_BASE: rd_mux = s.instr_space_base;
      IDX_ISPACE_LIMIT: rd_mux = s.instr_space_limit;
      IDX_DSPACE_BASE: rd_mux = s.data_space_base;
      IDX_DSPACE_LIMIT: rd_mux = s.data_space_limit;
      IDX_FAULT_VADDR: rd_mux = s.badva;
      IDX_CYCLE_COUNT: rd_mux = s.count;
      IDX_TIMER_CMP: rd_mux = s.compare;
      IDX_STATUS: rd_mux = s.status;
      IDX_EXC_CAUSE: rd_mux = s.cause;
      IDX_EXC_PC: rd_mux = s.exception_return_pc;
      IDX_PROC_ID: rd_mux = PROC_ID;
      IDX_SYS_ATTR: rd_mux = s.sysattr;
      IDX_REGION_POLICY: rd_mux = s.region_cache_policy;
      IDX_INSTR_BREAKPOINT_ADDR: rd_mux = s.instr_breakpoint_addr;
      IDX_DATA_BREAKPOINT_ADDR: rd_mux = s.data_breakpoint_addr;
      IDX_DIAG_CHECK: rd_mux = s.ecc;
      IDX_CACHE_FAULT: rd_mux = s.cerr;
      IDX_TAG_LOW: rd_mux = s.cache_tag_low;
      IDX_ERR_PC: rd_mux = s.errpc;
      IDX_IRQ_STATUS: rd_mux = {29'h0000_0000, s.irq_st};
      IDX_IRQ_MASK: rd_mux = {29'h0000_0000, s.irq_mask};
      default: rd_mux = ZERO32;
    endcase
  end

  // write happens once address and data are both held
  assign wr_commit = s.aw_held && s.w_held && !s.bvalid;
  assign count_written = wr_commit && (s.aw_idx == IDX_CYCLE_COUNT);
  // counter steps on odd cycles; match taken as it steps onto compare
  assign timer_hit = s.half && !count_written && ((s.count + 32'h0000_0001) == s.compare);

  // next-state logic
  always_comb begin
    next_s = s;
    // axi write address and data capture
    if (awvalid_in && s.aw_rdy) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = awaddr_in[7:2];
    end
    if (wvalid_in && s.w_rdy) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata_in;
      next_s.w_strb = wstrb_in;
    end
    if (s.bvalid && bready_in) begin
      next_s.bvalid = 1'b0;
    end
    // cycle counter at half rate
    next_s.half = !s.half;
    if (s.half) begin
      next_s.count = s.count + 32'h0000_0001;
    end
    // register writes
    if (wr_commit) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      case (s.aw_idx)
        IDX_ISPACE_BASE: next_s.instr_space_base = merge(s.instr_space_base, s.w_data, s.w_strb);
        IDX_ISPACE_LIMIT: next_s.instr_space_limit = merge(s.instr_space_limit, s.w_data, s.w_strb);
        IDX_DSPACE_BASE: next_s.data_space_base = merge(s.data_space_base, s.w_data, s.w_strb);
        IDX_DSPACE_LIMIT: next_s.data_space_limit = merge(s.data_space_limit, s.w_data, s.w_strb);
        IDX_CYCLE_COUNT: next_s.count = merge(s.count, s.w_data, s.w_strb);
        IDX_TIMER_CMP: begin
          next_s.compare = merge(s.compare, s.w_data, s.w_strb);
          next_s.cause[CAUSE_TIMER] = 1'b0;
        end
        IDX_STATUS: next_s.status = merge(s.status, s.w_data, s.w_strb);
        IDX_EXC_PC: next_s.exception_return_pc = merge(s.exception_return_pc, s.w_data, s.w_strb);
        IDX_SYS_ATTR: next_s.sysattr = merge(s.sysattr, s.w_data, s.w_strb);
        IDX_REGION_POLICY: next_s.region_cache_policy = merge(s.region_cache_policy, s.w_data, s.w_strb);
        IDX_INSTR_BREAKPOINT_ADDR: next_s.instr_breakpoint_addr = merge(s.instr_breakpoint_addr, s.w_data, s.w_strb);
        IDX_DATA_BREAKPOINT_ADDR: next_s.data_breakpoint_addr = merge(s.data_breakpoint_addr, s.w_data, s.w_strb);
        IDX_DIAG_CHECK: next_s.ecc = merge(s.ecc, s.w_data, s.w_strb);
        IDX_TAG_LOW: next_s.cache_tag_low = merge(s.cache_tag_low, s.w_data, s.w_strb);
        IDX_ERR_PC: next_s.errpc = merge(s.errpc, s.w_data, s.w_strb);
        IDX_IRQ_STATUS: next_s.irq_st = s.irq_st & ~s.w_data[NUM_EV-1:0];
        IDX_IRQ_MASK: next_s.irq_mask = s.w_data[NUM_EV-1:0];
        default: next_s.irq_mask = next_s.irq_mask; // read-only or unused
      endcase
    end
    // axi read: one beat held until taken
    if (s.rvalid && rready_in) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid_in && s.ar_rdy) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_mux;
    end
    // translation results, one cycle after the request
    next_s.f_valid = fetch_valid_in;
    next_s.f_paddr = xi_paddr;
    next_s.f_fault = fetch_valid_in && xi_fault;
    next_s.d_valid = data_valid_in;
    next_s.d_paddr = xd_paddr;
    next_s.d_fault = data_valid_in && xd_fault;
    next_s.watch_exc = (fetch_valid_in && xi_watch) || (data_valid_in && xd_watch);
    // fault address capture, data side takes priority
    if (data_valid_in && xd_fault) begin
      next_s.badva = data_vaddr_in;
    end else if (fetch_valid_in && xi_fault) begin
      next_s.badva = fetch_vaddr_in;
    end
    // hardware events win over software clears
    if (timer_hit) begin
      next_s.cause[CAUSE_TIMER] = 1'b1;
      next_s.irq_st[EV_TIMER] = 1'b1;
    end
    if (next_s.f_fault || next_s.d_fault) begin
      next_s.irq_st[EV_ADDR] = 1'b1;
    end
    if (next_s.watch_exc) begin
      next_s.irq_st[EV_WATCH] = 1'b1;
    end
    // exception recognised by the pipeline
    if (exc_take_in) begin
      next_s.status[ST_USER] = 1'b0;
      next_s.cause[CAUSE_CODE_LSB +: 5] = exc_code_in;
      if (exc_cache_err_in) begin
        next_s.errpc = exc_pc_in;
        next_s.cerr = cache_err_info_in;
      end else begin
        next_s.exception_return_pc = exc_pc_in;
      end
      if (exc_code_in == EXC_CODE_INT && s.status[ST_IVEC_EN]) begin
        next_s.exc_vec = VEC_INTERRUPT;
      end else begin
        next_s.exc_vec = VEC_GENERAL;
      end
    end
    // ready and derived outputs registered from the next state
    next_s.aw_rdy = !next_s.aw_held;
    next_s.w_rdy = !next_s.w_held;
    next_s.ar_rdy = !next_s.rvalid;
    next_s.ctl_ok = !next_s.status[ST_USER] || next_s.status[ST_CTL_USER_OK];
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
  end

  // state register; reset enters kernel mode
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.status <= STATUS_RESET;
      s.aw_rdy <= 1'b1;
      s.w_rdy <= 1'b1;
      s.ar_rdy <= 1'b1;
      s.ctl_ok <= 1'b1;
      s.exc_vec <= VEC_GENERAL;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state; both responses tied to RESP_OKAY
  assign awready_out = s.aw_rdy;
  assign wready_out = s.w_rdy;
  assign bvalid_out = s.bvalid;
  assign bresp_out = RESP_OKAY;
  assign arready_out = s.ar_rdy;
  assign rvalid_out = s.rvalid;
  assign rdata_out = s.rdata;
  assign rresp_out = RESP_OKAY;
  assign fetch_valid_out = s.f_valid;
  assign fetch_paddr_out = s.f_paddr;
  assign fetch_fault_out = s.f_fault;
  assign data_valid_out = s.d_valid;
  assign data_paddr_out = s.d_paddr;
  assign data_fault_out = s.d_fault;
  assign watch_exc_out = s.watch_exc;
  assign user_mode_out = s.status[ST_USER];
  assign ctl_usable_out = s.ctl_ok;
  assign fpu_usable_out = s.status[ST_FPU_EN];
  assign exc_vector_out = s.exc_vec;
  assign irq_out = s.irq;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  chk_count_step: assert property (s.half && !wr_commit |=> s.count == $past(s.count) + 1)
    else $error("count did not step on odd cycle");
  chk_count_hold: assert property (!s.half && !wr_commit |=> $stable(s.count))
    else $error("count stepped on even cycle");
  chk_timer_set: assert property (timer_hit |=> s.cause[CAUSE_TIMER] ##1 irq_out || !s.irq_mask[EV_TIMER])
    else $error("timer match not flagged");
  chk_fault_vaddr: assert property (data_valid_in && xd_fault |=> s.badva == $past(data_vaddr_in))
    else $error("faulting address not captured");
  chk_kernel_entry: assert property (exc_take_in |=> !user_mode_out)
    else $error("exception left user mode set");
  chk_ctl_gate: assert property (user_mode_out && !s.status[ST_CTL_USER_OK] |-> !ctl_usable_out)
    else $error("control access allowed in user mode");
  chk_user_kseg: assert property (fetch_valid_in && user_mode_out && fetch_vaddr_in[31] |=> fetch_fault_out)
    else $error("user kernel segment fetch not faulted");
  chk_data_bound: assert property (data_valid_in && user_mode_out && !data_vaddr_in[31] && data_vaddr_in <= s.data_space_limit
    |=> !data_fault_out && data_paddr_out == $past(data_vaddr_in) + $past(s.data_space_base))
    else $error("in-bounds data access mistranslated");
  chk_out_bound: assert property (fetch_valid_in && user_mode_out && fetch_vaddr_in > s.instr_space_limit |=> fetch_fault_out)
    else $error("out-of-bounds fetch not faulted");
  chk_kseg_map: assert property (fetch_valid_in && fetch_vaddr_in[31]
    |=> fetch_paddr_out == ($past(fetch_vaddr_in) & KSEG_PHYS_MASK))
    else $error("kernel address not fixed-mapped");
  chk_watch_hit: assert property (data_valid_in && s.status[ST_WATCH_EN] && data_vaddr_in[31:2] == s.data_breakpoint_addr[31:2]
    |=> watch_exc_out)
    else $error("data watch missed");
  chk_int_vector: assert property (exc_take_in && exc_code_in == EXC_CODE_INT && s.status[ST_IVEC_EN]
    |=> exc_vector_out == VEC_INTERRUPT)
    else $error("interrupt vector not used");
  chk_exc_pc: assert property (exc_take_in && !exc_cache_err_in |=> s.exception_return_pc == $past(exc_pc_in))
    else $error("exception pc not recorded");
  chk_cmp_clear: assert property (wr_commit && s.aw_idx == IDX_TIMER_CMP && !timer_hit |=> !s.cause[CAUSE_TIMER])
    else $error("compare write left timer pending");
  cov_timer: cover property (timer_hit ##2 irq_out);
  cov_user_fault: cover property (data_valid_in && user_mode_out ##1 data_fault_out);
  cov_int_exc: cover property (exc_take_in && exc_code_in == EXC_CODE_INT && s.status[ST_IVEC_EN]);
endmodule
`default_nettype wire

/* File: src/scc_pkg.sv */
// constants shared by the system control coprocessor block
package scc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_ISPACE_BASE = 6'h00;
  localparam logic [5:0] IDX_ISPACE_LIMIT = 6'h01;
  localparam logic [5:0] IDX_DSPACE_BASE = 6'h02;
  localparam logic [5:0] IDX_DSPACE_LIMIT = 6'h03;
  localparam logic [5:0] IDX_FAULT_VADDR = 6'h08;
  localparam logic [5:0] IDX_CYCLE_COUNT = 6'h09;
  localparam logic [5:0] IDX_TIMER_CMP = 6'h0b;
  localparam logic [5:0] IDX_STATUS = 6'h0c;
  localparam logic [5:0] IDX_EXC_CAUSE = 6'h0d;
  localparam logic [5:0] IDX_EXC_PC = 6'h0e;
  localparam logic [5:0] IDX_PROC_ID = 6'h0f;
  localparam logic [5:0] IDX_SYS_ATTR = 6'h10;
  localparam logic [5:0] IDX_REGION_POLICY = 6'h11;
  localparam logic [5:0] IDX_INSTR_BREAKPOINT_ADDR = 6'h12;
  localparam logic [5:0] IDX_DATA_BREAKPOINT_ADDR = 6'h13;
  localparam logic [5:0] IDX_DIAG_CHECK = 6'h1a;
  localparam logic [5:0] IDX_CACHE_FAULT = 6'h1b;
  localparam logic [5:0] IDX_TAG_LOW = 6'h1c;
  localparam logic [5:0] IDX_ERR_PC = 6'h1e;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
  // status register bit positions
  localparam int ST_USER = 0;
  localparam int ST_FPU_EN = 1;
  localparam int ST_CTL_USER_OK = 2;
  localparam int ST_WATCH_EN = 3;
  localparam int ST_IVEC_EN = 4;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  // cause register fields
  localparam int CAUSE_TIMER = 15;
  localparam int CAUSE_CODE_LSB = 2;
  localparam logic [4:0] EXC_CODE_INT = 5'h00;
  // interrupt event bits
  localparam int EV_TIMER = 0;
  localparam int EV_ADDR = 1;
  localparam int EV_WATCH = 2;
  localparam int NUM_EV = 3;
  // exception vectors and kernel segment mapping
  localparam logic [31:0] VEC_GENERAL = 32'h8000_0180;
  localparam logic [31:0] VEC_INTERRUPT = 32'h8000_0200;
  localparam logic [31:0] KSEG_PHYS_MASK = 32'h1fff_ffff;
  localparam int COUNT_DIV = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

/* File: src/scc_xlate.sv */
// address translation, bound check and watch match for one access stream
`timescale 1ns/1ps
`default_nettype none
module scc_xlate (
  // access
  input wire logic [31:0] vaddr_in,
  input wire logic user_in,
  // base, limit and watch settings
  input wire logic [31:0] base_in,
  input wire logic [31:0] limit_in,
  input wire logic [31:0] watch_addr_in,
  input wire logic watch_en_in,
  // results
  output logic [31:0] paddr_out,
  output logic fault_out,
  output logic watch_hit_out
);
  import scc_pkg::*;
  logic kseg;
  // top half of the space is kernel only
  assign kseg = vaddr_in[31];
  // kernel addresses use a fixed map, user ones add the base
  always_comb begin
    if (kseg) begin
      paddr_out = vaddr_in & KSEG_PHYS_MASK;
    end else begin
      paddr_out = vaddr_in + base_in;
    end
  end
  // user fault: kernel segment or beyond the limit (limit itself is inside)
  assign fault_out = user_in && (kseg || (vaddr_in > limit_in));
  // watch compares the word address
  assign watch_hit_out = watch_en_in && (vaddr_in[31:2] == watch_addr_in[31:2]);
endmodule
`default_nettype wire

/* File: dv/scc_pipe_model.sv */
// pipeline-side model that issues accesses and exception reports
`timescale 1ns/1ps
`default_nettype none
module scc_pipe_model (
  // clock
  input wire logic clock_in,
  // fetch and data requests
  output logic fetch_valid_out,
  output logic [31:0] fetch_vaddr_out,
  output logic data_valid_out,
  output logic [31:0] data_vaddr_out,
  // exception report
  output logic exc_take_out,
  output logic [4:0] exc_code_out,
  output logic [31:0] exc_pc_out,
  output logic exc_cerr_out,
  output logic [31:0] cerr_info_out
);
  // idle values; address lines carry junk between requests
  initial begin
    fetch_valid_out = 1'b0;
    fetch_vaddr_out = 32'h5a5a_5a5a;
    data_valid_out = 1'b0;
    data_vaddr_out = 32'ha5a5_a5a5;
    exc_take_out = 1'b0;
    exc_code_out = 5'h1f;
    exc_pc_out = 32'h3c3c_3c3c;
    exc_cerr_out = 1'b0;
    cerr_info_out = 32'hc3c3_c3c3;
  end
  // one-cycle fetch and data request, lines inverted once released
  task automatic access(input logic [31:0] fa, input logic fv, input logic [31:0] da,
    input logic dv);
    @(posedge clock_in);
    fetch_valid_out <= fv;
    fetch_vaddr_out <= fa;
    data_valid_out <= dv;
    data_vaddr_out <= da;
    @(posedge clock_in);
    fetch_valid_out <= 1'b0;
    fetch_vaddr_out <= ~fa;
    data_valid_out <= 1'b0;
    data_vaddr_out <= ~da;
  endtask
  // one-cycle exception report
  task automatic raise(input logic [4:0] code, input logic [31:0] pc, input logic ce);
    @(posedge clock_in);
    exc_take_out <= 1'b1;
    exc_code_out <= code;
    exc_pc_out <= pc;
    exc_cerr_out <= ce;
    cerr_info_out <= ~pc;
    @(posedge clock_in);
    exc_take_out <= 1'b0;
    exc_code_out <= ~code;
    exc_pc_out <= ~pc;
    exc_cerr_out <= 1'b0;
    cerr_info_out <= pc;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the system control coprocessor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, fv_o, ff_o, dv_o, df_o, wx_o;
  logic um_o, cu_o, fu_o, irq, fv, dv, xt, xce;
  logic [1:0] bresp, rresp;
  logic [4:0] xcd;
  logic [31:0] rdata, fpa, dpa, vec, rd, fa, da, xpc, xci, fva, c1, g, d;
  logic [31:0] mreg [int];
  int rw_q[$] = '{0, 1, 2, 3, 'h0e, 'h11, 'h12, 'h13, 'h1a, 'h1c, 'h1e};
  int un_q[$] = '{4, 5, 6, 7, 'h0a, 'h14, 'h15, 'h16, 'h17, 'h18, 'h19, 'h1d, 'h1f};
  int error_cnt = 0, checked = 0, cyc = 0, rcyc = 0, t1 = 0, n = 0;
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;
  scc_pipe_model pipe (.clock_in(clock_in), .fetch_valid_out(fv), .fetch_vaddr_out(fa),
    .data_valid_out(dv), .data_vaddr_out(da), .exc_take_out(xt), .exc_code_out(xcd),
    .exc_pc_out(xpc), .exc_cerr_out(xce), .cerr_info_out(xci));
  scc_top uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .awvalid_in(awvalid),
    .awaddr_in(awaddr), .awready_out(awready), .wvalid_in(wvalid), .wdata_in(wdata),
    .wstrb_in(4'hf), .wready_out(wready), .bvalid_out(bvalid), .bresp_out(bresp),
    .bready_in(bready), .arvalid_in(arvalid), .araddr_in(araddr), .arready_out(arready),
    .rvalid_out(rvalid), .rdata_out(rdata), .rresp_out(rresp), .rready_in(rready),
    .fetch_valid_in(fv), .fetch_vaddr_in(fa), .data_valid_in(dv), .data_vaddr_in(da),
    .exc_take_in(xt), .exc_code_in(xcd), .exc_pc_in(xpc), .exc_cache_err_in(xce),
    .cache_err_info_in(xci), .fetch_valid_out(fv_o), .fetch_paddr_out(fpa),
    .fetch_fault_out(ff_o), .data_valid_out(dv_o), .data_paddr_out(dpa),
    .data_fault_out(df_o), .watch_exc_out(wx_o), .user_mode_out(um_o),
    .ctl_usable_out(cu_o), .fpu_usable_out(fu_o), .exc_vector_out(vec), .irq_out(irq));
  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // bounded wait step
  task automatic guard(inout int k);
    k++;
    if (k > 300) begin
      error_cnt++;
      $display("MISMATCH t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask
  // axi4-lite write; model copy follows every write
  task automatic axi_wr(input logic [5:0] idx, input logic [31:0] dat);
    int k;
    logic pa, pw, a_ok, w_ok, ok;
    k = 0;
    pa = 1'b1;
    pw = 1'b1;
    ok = 1'b0;
    @(posedge clock_in);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= dat;
    bready <= 1'b1;
    while (pa || pw || !ok) begin
      @(negedge clock_in);
      a_ok = pa && awready;
      w_ok = pw && wready;
      ok = bvalid;
      if (ok) cmp_word({30'h0, bresp}, {30'h0, RESP_OKAY});
      @(posedge clock_in);
      if (a_ok) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (w_ok) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
      guard(k);
    end
    bready <= 1'b0;
    mreg[idx] = dat;
  endtask
  // axi4-lite read into rd
  task automatic axi_rd(input logic [5:0] idx);
    int k;
    logic ok;
    k = 0;
    ok = 1'b0;
    @(posedge clock_in);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    while (!ok) begin
      @(negedge clock_in);
      ok = arready;
      @(posedge clock_in);
      guard(k);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock_in);
      ok = rvalid;
      rd = rdata;
      rcyc = cyc;
      @(posedge clock_in);
      guard(k);
    end
    rready <= 1'b0;
  endtask
  // parallel fetch and data access against the translation model
  task automatic xl(input logic [31:0] a, input logic [31:0] b);
    logic u, fe, de;
    u = mreg[IDX_STATUS][ST_USER];
    fe = u && (a[31] || a > mreg[IDX_ISPACE_LIMIT]);
    de = u && (b[31] || b > mreg[IDX_DSPACE_LIMIT]);
    pipe.access(a, 1'b1, b, 1'b1);
    #1;
    cmp_bit(fv_o & dv_o, 1'b1);
    cmp_bit(ff_o, fe);
    cmp_bit(df_o, de);
    if (!fe) cmp_word(fpa, a[31] ? a & KSEG_PHYS_MASK : a + mreg[IDX_ISPACE_BASE]);
    if (!de) cmp_word(dpa, b[31] ? b & KSEG_PHYS_MASK : b + mreg[IDX_DSPACE_BASE]);
    if (de) fva = b;
    else if (fe) fva = a;
  endtask
  task automatic exc(input logic [4:0] code, input logic [31:0] pc, input logic ce);
    pipe.raise(code, pc, ce);
    #1;
    mreg[IDX_STATUS][ST_USER] = 1'b0;
    cmp_bit(um_o, 1'b0);
    cmp_word(vec, (code == EXC_CODE_INT && mreg[IDX_STATUS][ST_IVEC_EN]) ? VEC_INTERRUPT
      : VEC_GENERAL);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hc019));
    mreg[IDX_STATUS] = 32'h0;
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    cmp_bit(um_o, 1'b0);
    cmp_bit(cu_o, 1'b1);
    cmp_word(vec, VEC_GENERAL);
    foreach (rw_q[i]) axi_wr(rw_q[i][5:0], $urandom);
    foreach (rw_q[i]) begin
      axi_rd(rw_q[i][5:0]);
      cmp_word(rd, mreg[rw_q[i]]);
    end
    axi_wr(IDX_FAULT_VADDR, 32'h1234_5678);
    axi_rd(IDX_FAULT_VADDR);
    cmp_word(rd, 32'h0);
    foreach (un_q[i]) begin
      axi_rd(un_q[i][5:0]);
      cmp_word(rd, 32'h0);
    end
    $display("test registers done");
    axi_wr(IDX_STATUS, 32'h1);
    repeat (2) @(posedge clock_in);
    #1;
    cmp_word({um_o, cu_o, fu_o}, 3'b100);
    axi_wr(IDX_STATUS, 32'h7);
    repeat (2) @(posedge clock_in);
    #1;
    cmp_word({um_o, cu_o, fu_o}, 3'b111);
    $display("test modes done");
    axi_wr(IDX_ISPACE_BASE, 32'h0010_0000);
    axi_wr(IDX_ISPACE_LIMIT, 32'h0000_7fff);
    axi_wr(IDX_DSPACE_BASE, 32'h0020_0000);
    axi_wr(IDX_DSPACE_LIMIT, 32'h0000_3fff);
    xl(32'h0000_7fff, 32'h0000_3fff);
    xl(32'h0000_8000, 32'h0000_4000);
    xl(32'h8000_0010, 32'h0000_0000);
    repeat (16) xl($urandom & 32'h8000_ffff, $urandom & 32'h8000_7fff);
    axi_rd(IDX_FAULT_VADDR);
    cmp_word(rd, fva);
    axi_rd(IDX_IRQ_STATUS);
    #1;
    cmp_word(rd, 32'h2);
    cmp_bit(irq, 1'b0);
    axi_wr(IDX_IRQ_MASK, 32'h2);
    #1;
    cmp_bit(irq, 1'b1);
    axi_wr(IDX_IRQ_STATUS, 32'h2);
    #1;
    cmp_bit(irq, 1'b0);
    xl(32'h0000_9000, 32'h0000_0000);
    cmp_bit(irq, 1'b1);
    axi_wr(IDX_IRQ_STATUS, 32'h7);
    axi_wr(IDX_IRQ_MASK, 32'h0);
    $display("test translation done");
    exc(5'h04, 32'h0000_0400, 1'b0);
    axi_rd(IDX_EXC_PC);
    cmp_word(rd, 32'h0000_0400);
    xl(32'h9000_1234, 32'ha000_0040);
    axi_wr(IDX_STATUS, 32'h10);
    exc(5'h00, 32'h0000_0500, 1'b0);
    exc(5'h04, 32'h0000_0600, 1'b0);
    exc(5'h1e, 32'h0000_0880, 1'b1);
    axi_rd(IDX_ERR_PC);
    cmp_word(rd, 32'h0000_0880);
    $display("test exceptions done");
    axi_wr(IDX_INSTR_BREAKPOINT_ADDR, 32'h9000_0100);
    axi_wr(IDX_DATA_BREAKPOINT_ADDR, 32'h9000_0200);
    for (int i = 0; i < 4; i++) begin
      axi_wr(IDX_STATUS, (i == 3) ? 32'h0 : 32'h8);
      pipe.access(32'h9000_0100 + ((i == 2) ? 32'h4 : 32'h0), i != 1,
        32'h9000_0200 + ((i == 2) ? 32'h4 : 32'h0), i != 0);
      #1;
      cmp_bit(wx_o, i < 2);
    end
    axi_wr(IDX_IRQ_STATUS, 32'h7);
    $display("test watch done");
    axi_rd(IDX_CYCLE_COUNT);
    c1 = rd;
    t1 = rcyc;
    repeat (100) @(posedge clock_in);
    axi_rd(IDX_CYCLE_COUNT);
    g = rcyc - t1;
    d = rd - c1;
    // reset ends at edge 8, so the count steps on edges 10, 12 and on;
    // a read taken at edge e returns (e - 9) / 2
    cmp_word(d, ((t1 + g - 9) / 2) - ((t1 - 9) / 2));
    axi_wr(IDX_IRQ_MASK, 32'h1);
    axi_wr(IDX_TIMER_CMP, rd + 32'd40);
    while (irq !== 1'b1) begin
      @(posedge clock_in);
      guard(n);
    end
    axi_rd(IDX_IRQ_STATUS);
    cmp_word(rd, 32'h1);
    axi_rd(IDX_EXC_CAUSE);
    cmp_bit(rd[CAUSE_TIMER], 1'b1);
    axi_wr(IDX_TIMER_CMP, 32'h0);
    axi_rd(IDX_EXC_CAUSE);
    cmp_bit(rd[CAUSE_TIMER], 1'b0);
    axi_wr(IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock_in);
    #1;
    cmp_bit(irq, 1'b0);
    $display("test timer done");
    finish_test();
  end
endmodule
`default_nettype wire
